// ===== hdl/sir_defines.vh
`ifndef SIR_DEFINES_VH
`define SIR_DEFINES_VH

// ----------------------------------------
// register map (byte addresses on a 4-bit port)
// ----------------------------------------
`define SIR_ADDR_TARGET_ID 4'h4
`define SIR_ADDR_INTR 4'h5
`define SIR_ADDR_TMO 4'h5
`define SIR_ADDR_SEQ 4'h6
`define SIR_ADDR_PERIOD 4'h6

// ----------------------------------------
// interrupt cause bit positions
// ----------------------------------------
`define SIR_BIT_BUS_RESET 7
`define SIR_BIT_BAD_CMD 6
`define SIR_BIT_DROPPED 5
`define SIR_BIT_SERVICE 4
`define SIR_BIT_DONE 3
`define SIR_BIT_PICKED_AS_INITIATOR_FLAG 2
`define SIR_BIT_SEL_ATN 1
`define SIR_BIT_SEL 0

// ----------------------------------------
// sequence progress fields
// ----------------------------------------
`define SIR_SEQ_OFS_BIT 3
`define SIR_SEQ_RST 3'h0

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define SIR_INTR_RST 8'h00
`define SIR_PERIOD_RST 5'h05
`define SIR_PERIOD_DIRECT_MIN 5'h04
`define SIR_PERIOD_WRAP 6'h20
`define SIR_CCF_ZERO_AS 4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define SIR_CLK_HZ 25000000
`define SIR_TMO_UNIT 8192
`define SIR_TMO_HOST_MS 250

`endif

// ===== hdl/sir_regs.v
// ----------------------------------------
// Overview of operation
// - low three target-id bits encode bus id; code 7 drives bit pattern 80h.
// - target id untouched by every reset; unknown until first host write.
// - cause read while interrupt asserted clears cause, status and sequence step.
// - cause register zeroed by hard reset or chip reset, kept on bus reset.
// - bus-reset-seen flag set on bus reset unless reporting is disabled.
// - bad-command flag set, with interrupt, on reserved or wrong-mode command.
// - link-dropped flag set on disconnect, selection time-out or target leaving bus.
// - service-request flag set on attention as target or phase request as initiator.
// - function-done flag set when target command or initiator step completes.
// - picked-as-initiator flag set when another device reselects us.
// - selected as target sets bit 1 with attention, bit 0 without.
// - selection wait ends after count times 8192 times conversion factor clocks.
// - conversion factor zero counts as eight.
// - time-out neither starts nor runs before arbitration is won.
// - time-out count untouched by every reset; unknown after power-up.
// - progress counter zeroed at sequenced command start, stepped at set points.
// - progress cleared on hard reset, soft reset and pending cause read.
// - progress bit 3 reads low when offset counter is at maximum.
// - sync edges spaced N clocks; field 0..3 means 32..35, else N.
// - sync period loads five on hard or chip reset, kept on bus reset.
// - interrupt output and summary bit drop on hard reset, chip reset, cause read.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "sir_defines.vh"

module sir_regs #(
  parameter [16:0] TMO_UNIT = `SIR_TMO_UNIT
) (
  input wire i_clk,               // 25 MHz system clock
  input wire i_arst_n,            // async hard reset, active low
  input wire i_ce,                // clock enable, freezes all state
  input wire [3:0] i_addr,        // register address
  input wire [7:0] i_wdata,       // write data
  input wire i_wr,                // write strobe
  input wire i_rd,                // read strobe
  output reg [7:0] o_rdata,       // read data, cycle after strobe
  input wire i_chip_reset,        // chip reset command pulse
  input wire i_bus_reset_pin,     // bus reset line, asynchronous
  input wire i_rst_report_dis,    // reset reporting disable bit
  input wire i_bad_cmd,           // reserved or wrong-mode command
  input wire i_link_dropped,      // disconnect event
  input wire i_service_req,       // attention or phase request
  input wire i_function_done,     // command or step complete
  input wire i_reselected,        // reselected by another device
  input wire i_selected_atn,      // selected, attention asserted
  input wire i_selected,          // selected, attention false
  input wire i_seq_zero,          // sequenced command start
  input wire i_seq_step,          // sequence point reached
  input wire i_offset_at_max,     // sync offset counter at maximum
  input wire [2:0] i_clk_conv,    // clock conversion factor field
  input wire i_sel_wait,          // waiting for selection response
  input wire i_arb_won,           // arbitration won
  input wire i_sync_active,       // synchronous transfer running
  output reg o_irq_n,             // interrupt output, active low
  output reg o_int_pending,       // interrupt summary status bit
  output reg o_status_clear,      // pulse: clear status register
  output reg [2:0] o_target_id,   // encoded target bus id
  output reg [7:0] o_target_bus,  // target id as bus data bit
  output reg o_sel_timeout,       // pulse: selection time-out
  output reg [5:0] o_period_clks, // clocks per sync byte
  output reg o_sync_edge          // pulse: next req/ack lead edge
);

  // ----------------------------------------
  // bus reset synchroniser
  // ----------------------------------------
  reg bus_rst_meta_r;
  reg bus_rst_r;

  // two flops; only the second is looked at
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_rst_meta_r <= 1'b0;
      bus_rst_r <= 1'b0;
    end else if (i_ce) begin
      bus_rst_meta_r <= i_bus_reset_pin;
      bus_rst_r <= bus_rst_meta_r;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire wr_tid = i_wr & (i_addr == `SIR_ADDR_TARGET_ID);
  wire wr_tmo = i_wr & (i_addr == `SIR_ADDR_TMO);
  wire wr_per = i_wr & (i_addr == `SIR_ADDR_PERIOD);
  wire rd_intr = i_rd & (i_addr == `SIR_ADDR_INTR);
  wire rd_seq = i_rd & (i_addr == `SIR_ADDR_SEQ);

  // a read only clears while the interrupt is really asserted
  wire intr_clr = rd_intr & o_int_pending;

  // ----------------------------------------
  // target id and time-out count
  // ----------------------------------------
  reg [7:0] tmo_count_r;

  // no reset at all: these survive every reset kind
  always @(posedge i_clk) begin
    if (i_ce) begin
      if (wr_tid) begin
        o_target_id <= i_wdata[2:0];
        o_target_bus <= 8'h01 << i_wdata[2:0];
      end
      if (wr_tmo) begin
        tmo_count_r <= i_wdata;
      end
    end
  end

  // ----------------------------------------
  // selection time-out
  // ----------------------------------------
  // prescaler spans unit times factor clocks, then one count goes
  wire [3:0] ccf = (i_clk_conv == 3'h0) ? `SIR_CCF_ZERO_AS : {1'b0, i_clk_conv};
  wire [20:0] pre_lim = TMO_UNIT * ccf;
  wire tmo_run = i_sel_wait & i_arb_won;

  reg [20:0] pre_r;
  reg [7:0] left_r;
  reg tmo_arm_r;
  reg [20:0] pre_nxt;
  reg [7:0] left_nxt;
  reg tmo_arm_nxt;
  reg tmo_fire;

  // a count of zero expires at the first prescale wrap
  always @* begin
    pre_nxt = pre_r;
    left_nxt = left_r;
    tmo_arm_nxt = tmo_arm_r;
    tmo_fire = 1'b0;
    if (!tmo_run) begin
      tmo_arm_nxt = 1'b0;
      pre_nxt = 21'h000000;
      left_nxt = 8'h00;
    end else if (!tmo_arm_r) begin
      tmo_arm_nxt = 1'b1;
      pre_nxt = 21'h000001;
      left_nxt = tmo_count_r;
    end else if (pre_r >= pre_lim) begin
      pre_nxt = 21'h000001;
      if (left_r <= 8'h01) begin
        tmo_fire = 1'b1;
        tmo_arm_nxt = 1'b0;
        left_nxt = 8'h00;
      end else begin
        left_nxt = left_r - 8'h01;
      end
    end else begin
      pre_nxt = pre_r + 21'h000001;
    end
  end

  // the wait restarts only after the sequencer drops it
  reg tmo_done_r;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_r <= 21'h000000;
      left_r <= 8'h00;
      tmo_arm_r <= 1'b0;
      tmo_done_r <= 1'b0;
      o_sel_timeout <= 1'b0;
    end else if (i_ce) begin
      if (i_chip_reset) begin
        pre_r <= 21'h000000;
        left_r <= 8'h00;
        tmo_arm_r <= 1'b0;
        tmo_done_r <= 1'b0;
        o_sel_timeout <= 1'b0;
      end else begin
        pre_r <= pre_nxt;
        left_r <= left_nxt;
        tmo_arm_r <= tmo_arm_nxt & ~tmo_done_r & ~tmo_fire;
        tmo_done_r <= tmo_run & (tmo_done_r | tmo_fire);
        o_sel_timeout <= tmo_fire & ~tmo_done_r;
      end
    end
  end

  wire tmo_evt = tmo_fire & ~tmo_done_r;

  // ----------------------------------------
  // interrupt cause
  // ----------------------------------------
  reg [7:0] intr_r;
  reg [7:0] set_v;
  reg [7:0] intr_nxt;

  // new events win over a clearing read in the same cycle
  always @* begin
    set_v = 8'h00;
    set_v[`SIR_BIT_BUS_RESET] = bus_rst_r & ~i_rst_report_dis;
    set_v[`SIR_BIT_BAD_CMD] = i_bad_cmd;
    set_v[`SIR_BIT_DROPPED] = i_link_dropped | tmo_evt;
    set_v[`SIR_BIT_SERVICE] = i_service_req;
    set_v[`SIR_BIT_DONE] = i_function_done;
    set_v[`SIR_BIT_PICKED_AS_INITIATOR_FLAG] = i_reselected;
    set_v[`SIR_BIT_SEL_ATN] = i_selected_atn;
    set_v[`SIR_BIT_SEL] = i_selected;
    intr_nxt = (intr_clr ? `SIR_INTR_RST : intr_r) | set_v;
  end

  // bus reset is not a reset for this register
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      intr_r <= `SIR_INTR_RST;
      o_int_pending <= 1'b0;
      o_irq_n <= 1'b1;
      o_status_clear <= 1'b0;
    end else if (i_ce) begin
      if (i_chip_reset) begin
        intr_r <= `SIR_INTR_RST;
        o_int_pending <= 1'b0;
        o_irq_n <= 1'b1;
        o_status_clear <= 1'b0;
      end else begin
        intr_r <= intr_nxt;
        o_int_pending <= |intr_nxt;
        o_irq_n <= ~(|intr_nxt);
        o_status_clear <= intr_clr;
      end
    end
  end

  // ----------------------------------------
  // sequence progress
  // ----------------------------------------
  reg [2:0] seq_r;
  reg [2:0] seq_nxt;

  // a step landing on the clearing read still counts
  always @* begin
    seq_nxt = seq_r;
    if (intr_clr) begin
      seq_nxt = `SIR_SEQ_RST;
    end
    if (i_seq_zero) begin
      seq_nxt = `SIR_SEQ_RST;
    end
    if (i_seq_step) begin
      seq_nxt = seq_nxt + 3'h1;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seq_r <= `SIR_SEQ_RST;
    end else if (i_ce) begin
      if (i_chip_reset) begin
        seq_r <= `SIR_SEQ_RST;
      end else begin
        seq_r <= seq_nxt;
      end
    end
  end

  // ----------------------------------------
  // synchronous period
  // ----------------------------------------
  reg [4:0] period_r;
  reg [5:0] sync_cnt_r;

  // codes below four wrap to the long end of the range
  wire [5:0] period_n = (period_r < `SIR_PERIOD_DIRECT_MIN) ?
    (`SIR_PERIOD_WRAP + {1'b0, period_r}) : {1'b0, period_r};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      period_r <= `SIR_PERIOD_RST;
    end else if (i_ce) begin
      if (i_chip_reset) begin
        period_r <= `SIR_PERIOD_RST;
      end else if (wr_per) begin
        period_r <= i_wdata[4:0];
      end
    end
  end

  // first edge at once, then one every period_n clocks
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_cnt_r <= 6'h00;
      o_sync_edge <= 1'b0;
      o_period_clks <= 6'h00;
    end else if (i_ce) begin
      o_period_clks <= period_n;
      if (!i_sync_active || i_chip_reset) begin
        sync_cnt_r <= 6'h00;
        o_sync_edge <= 1'b0;
      end else if (sync_cnt_r == 6'h00) begin
        sync_cnt_r <= period_n - 6'h01;
        o_sync_edge <= 1'b1;
      end else begin
        sync_cnt_r <= sync_cnt_r - 6'h01;
        o_sync_edge <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // unmapped and write-only addresses read as zero
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (rd_intr) begin
        o_rdata <= intr_r;
      end else if (rd_seq) begin
        o_rdata <= {4'h0, ~i_offset_at_max, seq_r};
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/sir_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sir_regs_checker (
  input wire logic i_clk, // clock
  input wire logic i_arst_n, // hard reset, low
  input wire logic i_ce, // clock enable
  input wire logic [3:0] i_addr, // address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic i_chip_reset, // chip reset pulse
  input wire logic i_bad_cmd, // bad command event
  input wire logic i_sel_wait, // selection wait
  input wire logic i_arb_won, // arbitration won
  input wire logic o_irq_n, // interrupt, low
  input wire logic o_int_pending, // summary bit
  input wire logic o_status_clear, // status clear pulse
  input wire logic [2:0] o_target_id, // target id
  input wire logic [7:0] o_target_bus, // id as bus bit
  input wire logic o_sel_timeout, // time-out pulse
  input wire logic [5:0] o_period_clks // clocks per byte
);
  // ------------------------------
  // helper state
  // ------------------------------
  logic rd5_r, clr_r, arm_r, chip_r;
  logic [5:0] per_exp;
  logic [2:0] id_exp;
  wire wr6 = i_wr && i_ce && i_addr == 4'h6;
  wire wr4 = i_wr && i_ce && i_addr == 4'h4;
  // past-cycle causes, kept here so no property needs $past
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd5_r <= 1'b0;
      clr_r <= 1'b0;
      arm_r <= 1'b0;
      chip_r <= 1'b0;
    end else begin
      rd5_r <= i_rd && i_addr == 4'h5;
      clr_r <= i_rd && i_addr == 4'h5 && o_int_pending;
      arm_r <= i_sel_wait && i_arb_won;
      chip_r <= i_chip_reset;
    end
  end
  // expected fields; codes under four wrap to 32..35
  always_ff @(posedge i_clk) begin
    if (wr6) per_exp <= {i_wdata[4:0] < 5'h04, i_wdata[4:0]};
    if (wr4) id_exp <= i_wdata[2:0];
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_pend;
    o_int_pending == !o_irq_n;
  endproperty
  a_pend: assert property (p_pend) else $error("summary bit wrong");
  property p_rel;
    $rose(o_irq_n) |-> rd5_r || chip_r;
  endproperty
  a_rel: assert property (p_rel) else $error("irq dropped");
  property p_bad;
    i_bad_cmd && !i_chip_reset |=> !o_irq_n;
  endproperty
  a_bad: assert property (p_bad) else $error("no irq");
  property p_clr;
    i_rd && i_ce && i_addr == 4'h5 && o_int_pending |=> o_status_clear ##1 !o_status_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("no status clear");
  property p_clr_src;
    o_status_clear |-> clr_r;
  endproperty
  a_clr_src: assert property (p_clr_src) else $error("stray clear");
  // the period output trails the register by one flop
  property p_chip;
    i_chip_reset |=> o_irq_n ##1 o_period_clks == 6'h05;
  endproperty
  a_chip: assert property (p_chip) else $error("chip reset");
  property p_per;
    wr6 ##1 !wr6 && !i_chip_reset |=> o_period_clks == per_exp;
  endproperty
  a_per: assert property (p_per) else $error("period wrong");
  property p_id;
    wr4 ##1 !wr4 |=> o_target_id == id_exp && o_target_bus == 8'h01 << id_exp;
  endproperty
  a_id: assert property (p_id) else $error("target id wrong");
  property p_tmo;
    o_sel_timeout |-> arm_r ##1 !o_sel_timeout;
  endproperty
  a_tmo: assert property (p_tmo) else $error("time-out unarmed");
endmodule
bind sir_regs sir_regs_checker u_chk (.*);
`default_nettype wire

// ===== test/sir_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sir_peer (
  input wire logic i_clk, // clock
  input wire logic i_go, // raise one event
  input wire logic [2:0] i_sel, // which event
  output logic [6:0] o_ev // one-cycle event pulses
);
  // ------------------------------
  // bus peers as sequencer events
  // ------------------------------
  // registered so every event lands as a clean one-cycle pulse
  always_ff @(posedge i_clk) begin
    o_ev <= i_go ? 7'(7'h01 << i_sel) : 7'h00;
  end
endmodule
`default_nettype wire

// ===== test/scsi_intr_seq_timeout_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scsi_intr_seq_timeout_regs_tb;
  // ------------------------------
  // stimulus and instances
  // ------------------------------
  logic i_clk = 0, i_arst_n = 0, i_ce = 1, i_wr = 0, i_rd = 0, i_chip_reset = 0;
  logic i_bus_reset_pin = 0, i_rst_report_dis = 0, i_seq_zero = 0, i_seq_step = 0;
  logic i_offset_at_max = 0, i_sel_wait = 0, i_arb_won = 0, i_sync_active = 0, go = 0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_target_bus, rd_v;
  logic [2:0] i_clk_conv = 3'h1, sel = 3'h0, o_target_id;
  logic [6:0] ev;
  logic [5:0] o_period_clks;
  logic o_irq_n, o_int_pending, o_status_clear, o_sel_timeout, o_sync_edge;
  int failures = 0, cmp_count = 0, n;
  always #20 i_clk = ~i_clk;
  sir_peer u_peer (.i_clk(i_clk), .i_go(go), .i_sel(sel), .o_ev(ev));
  // short prescale keeps time-out runs brief
  sir_regs #(.TMO_UNIT(17'd4)) u_dut (.*, .i_selected(ev[0]), .i_selected_atn(ev[1]),
    .i_reselected(ev[2]), .i_function_done(ev[3]), .i_service_req(ev[4]),
    .i_link_dropped(ev[5]), .i_bad_cmd(ev[6]));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1 rd_v = o_rdata;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic fire(input logic [2:0] k);
    @(posedge i_clk);
    go <= 1;
    sel <= k;
    @(posedge i_clk);
    go <= 0;
    cyc(2);
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_hi(ref logic s, output int k);
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (s !== 1'b1 && k < 200);
    if (s !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset_vals;
    rd(4'h6);
    chk(rd_v, 8'h08);
    rd(4'h5);
    chk(rd_v, 8'h00);
    rd(4'h7);
    chk(rd_v, 8'h00); // unmapped
    chk({2'h0, o_period_clks}, 8'h05);
    @(posedge i_clk);
    i_offset_at_max <= 1;
    rd(4'h6);
    chk(rd_v, 8'h00);
    $display("test reset_vals done");
  endtask
  task automatic t_fields;
    logic [4:0] c;
    for (int i = 0; i < 8; i++) begin
      wr(4'h4, 8'(i));
      cyc(2);
      chk(o_target_bus, 8'(1 << i));
    end
    // never under four clocks per byte
    for (int i = 0; i < 6; i++) begin
      c = 5'(i == 5 ? 31 : i);
      wr(4'h6, {3'h0, c});
      cyc(2);
      chk({2'h0, o_period_clks}, 8'(c < 4 ? c + 32 : c));
    end
    // a write with the clock enable low must not land
    @(posedge i_clk);
    i_ce <= 0;
    wr(4'h6, 8'h09);
    @(posedge i_clk);
    i_ce <= 1;
    cyc(2);
    chk({2'h0, o_period_clks}, 8'h1f);
    $display("test fields done");
  endtask
  task automatic t_events;
    for (int k = 0; k < 7; k++) begin
      fire(3'(k));
      chk({7'h0, o_irq_n}, 8'h00);
      rd(4'h6);
      rd(4'h5);
      chk(rd_v, 8'(1 << k));
      chk({7'h0, o_irq_n}, 8'h01);
    end
    @(posedge i_clk);
    i_seq_zero <= 1;
    @(posedge i_clk);
    i_seq_zero <= 0;
    i_seq_step <= 1;
    repeat (3) @(posedge i_clk);
    i_seq_step <= 0;
    rd(4'h6);
    chk(rd_v, 8'h03);
    fire(3'd6);
    rd(4'h5);
    rd(4'h6);
    chk(rd_v, 8'h00);
    $display("test events done");
  endtask
  task automatic pin(input logic dis);
    @(posedge i_clk);
    i_rst_report_dis <= dis;
    i_bus_reset_pin <= 1;
    cyc(4);
    @(posedge i_clk);
    i_bus_reset_pin <= 0;
    cyc(4);
  endtask
  task automatic t_bus;
    pin(1'b1);
    chk({7'h0, o_irq_n}, 8'h01);
    pin(1'b0);
    rd(4'h5);
    chk(rd_v, 8'h80);
    chk({2'h0, o_period_clks}, 8'h1f);
    $display("test bus_reset done");
  endtask
  task automatic t_chip;
    fire(3'd6);
    @(posedge i_clk);
    i_chip_reset <= 1;
    @(posedge i_clk);
    i_chip_reset <= 0;
    cyc(2);
    chk({7'h0, o_irq_n}, 8'h01);
    chk({2'h0, o_period_clks}, 8'h05);
    chk(o_target_bus, 8'h80);
    rd(4'h5);
    chk(rd_v, 8'h00);
    $display("test chip_reset done");
  endtask
  // count written, then a hard reset before use
  task automatic t_tmo(input logic [2:0] f, input int cnt, input int lo);
    wr(4'h5, 8'(cnt)); // count scaled with the short prescale
    @(posedge i_clk);
    i_arst_n <= 0;
    cyc(2);
    @(posedge i_clk);
    i_arst_n <= 1;
    i_clk_conv <= f;
    i_sel_wait <= 1;
    cyc(60);
    rd(4'h5);
    chk(rd_v, 8'h00);
    @(posedge i_clk);
    i_arb_won <= 1;
    wait_hi(o_sel_timeout, n);
    chk(8'(n >= lo && n <= lo + 3), 8'h01);
    chk(o_target_bus, 8'h80);
    @(posedge i_clk);
    i_sel_wait <= 0;
    i_arb_won <= 0;
    rd(4'h5);
    chk(rd_v, 8'h20);
    $display("test timeout done");
  endtask
  task automatic t_sync(input logic [4:0] c, input int e);
    wr(4'h6, {3'h0, c});
    @(posedge i_clk);
    i_sync_active <= 1;
    repeat (3) wait_hi(o_sync_edge, n);
    chk(8'(n), 8'(e));
    @(posedge i_clk);
    i_sync_active <= 0;
    $display("test sync done");
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1;
    t_reset_vals();
    t_fields();
    t_events();
    t_bus();
    t_chip();
    t_tmo(3'd1, 2, 8);
    t_tmo(3'd0, 1, 32);
    t_sync(5'h06, 6);
    t_sync(5'h00, 32);
    end_of_test();
  end
endmodule
`default_nettype wire
